// ===== dv/fsd_master_model.sv
`timescale 1ns/1ps
module fsd_master_model (
  input wire pclk,
  input wire emcy_valid,
  input wire [63:0] emcy_data,
  output reg sm_event,
  output reg sync0,
  output reg sm_watchdog
);
  logic [63:0] rx_q[$];

  initial begin
    sm_event = 1'b0;
    sync0 = 1'b0;
    sm_watchdog = 1'b0;
  end

  // Messages are taken as they come; the model never answers them.
  always @(posedge pclk) begin
    if (emcy_valid === 1'b1) rx_q.push_back(emcy_data);
  end

  // One-cycle pulse: 0 event, 1 sync, 2 watchdog.
  task pulse(input int k);
    @(posedge pclk);
    {sm_watchdog, sync0, sm_event} <= 3'b001 << k;
    @(posedge pclk);
    {sm_watchdog, sync0, sm_event} <= 3'b000;
  endtask
endmodule

// ===== dv/fsd_slave_app_assertions.sv
`timescale 1ns/1ps
module fsd_slave_app_assertions (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire sup_overcurrent,
  input wire overtemp,
  input wire [31:0] io_status,
  input wire emcy_valid,
  input wire [63:0] emcy_data,
  input wire restore_defaults
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  // ----------------------------------------
  // Status word and emergency contents
  // ----------------------------------------
  resv_bits_zero_a: assert property (io_status[31:6] == 26'h0 && io_status[3:0] == 4'h0)
    else $error("reserved status bits set");
  emcy_codes_a: assert property (emcy_valid |-> emcy_data[15:0] inside
    {16'h0000, 16'h3001, 16'h3002, 16'h3003, 16'h4001})
    else $error("unknown emergency code");
  supply_ereg_a: assert property (emcy_valid && emcy_data[15:8] == 8'h30 |->
    emcy_data[18] && emcy_data[39:32] == emcy_data[7:0])
    else $error("supply message fields wrong");
  temp_ereg_a: assert property (emcy_valid && emcy_data[15:0] == 16'h4001 |->
    emcy_data[20] && emcy_data[39:32] == 8'h06)
    else $error("temperature message fields wrong");
  diag_pad_a: assert property (emcy_valid |-> emcy_data[31:24] == 8'h0 &&
    emcy_data[63:40] == 24'h0)
    else $error("diagnostic padding not zero");
  // The bound allows for a few other messages queued ahead.
  oc_msg_a: assert property ($rose(sup_overcurrent) |-> ##[1:8]
    (emcy_valid && emcy_data[15:0] == 16'h3001))
    else $error("no message on overcurrent");
  clr_msg_a: assert property ($fell(overtemp) |-> ##[1:8]
    (emcy_valid && emcy_data[15:0] == 16'h0000 && !emcy_data[20]))
    else $error("no clearance message");

  // ----------------------------------------
  // Restore request
  // ----------------------------------------
  restore_set_a: assert property (psel && penable && pready && pwrite && paddr == 8'h28 &&
    pwdata == 32'h1 |=> restore_defaults)
    else $error("restore request not taken");
  restore_hold_a: assert property (restore_defaults |=> restore_defaults)
    else $error("restore request lost");
endmodule

bind fsd_slave_app fsd_slave_app_assertions i_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .sup_overcurrent(sup_overcurrent),
  .overtemp(overtemp), .io_status(io_status), .emcy_valid(emcy_valid),
  .emcy_data(emcy_data), .restore_defaults(restore_defaults));

// ===== dv/fsd_slave_app_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module fsd_slave_app_tb;
  reg pclk, presetn, psel, penable, pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  reg er;
  reg [15:0] din;
  reg [3:0] flt, ok;
  wire [31:0] prdata, io_status;
  wire pready, pslverr, pd_update, emcy_valid, restore_defaults, sm_event, sync0, sm_wd;
  wire [15:0] proc_in;
  wire [63:0] emcy_data;
  logic [63:0] m;
  int fail_count = 0;
  int n_tests = 0;

  fsd_slave_app #(.SAMPLE_CYC(4)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .device_input_number(din),
    .sup_overcurrent(flt[0]), .sup_surge(flt[1]), .sup_undervoltage(flt[2]),
    .overtemp(flt[3]), .mbx_cfg_ok(ok[0]), .sm_cfg_ok(ok[1]), .out_cfg_ok(ok[2]),
    .in_cfg_ok(ok[3]), .sm_watchdog(sm_wd), .sm_event(sm_event), .sync0(sync0),
    .proc_in(proc_in), .io_status(io_status), .pd_update(pd_update),
    .emcy_valid(emcy_valid), .emcy_data(emcy_data), .restore_defaults(restore_defaults));
  fsd_master_model i_mst (.pclk(pclk), .emcy_valid(emcy_valid), .emcy_data(emcy_data),
    .sm_event(sm_event), .sync0(sync0), .sm_watchdog(sm_wd));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  // Read data is taken at the very edge that samples pready high, then the request is dropped.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fail_count++;
  endtask

  task stat(input logic [3:0] es, input logic [15:0] ec);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("status", {27'h0, ec != 16'h0, es}, rd)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("code", {16'h0, ec}, rd)
  endtask

  // Every request carries the acknowledge, so only a failure leaves the flag set.
  task req(input logic [3:0] s, input logic [3:0] es, input logic [15:0] ec);
    apb(1'b1, 8'h00, {27'h0, 1'b1, s});
    repeat (2) @(posedge pclk);
    stat(es, ec);
  endtask

  task wait_pd(output int n);
    n = 0;
    while (pd_update !== 1'b1 && n < 30) begin
      @(negedge pclk);
      n++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_states;
    stat(4'h1, 16'h0);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("mode", 32'h0, rd)
    req(4'h4, 4'h1, 16'h0011);
    req(4'h8, 4'h1, 16'h0011);
    req(4'h5, 4'h1, 16'h0012);
    ok <= 4'b1110;
    req(4'h3, 4'h1, 16'h0015);
    req(4'h2, 4'h1, 16'h0016);
    ok <= 4'hf;
    req(4'h2, 4'h2, 16'h0);
    req(4'h8, 4'h2, 16'h0011);
    req(4'h3, 4'h2, 16'h0011);
    ok <= 4'b1101;
    req(4'h4, 4'h2, 16'h0017);
    ok <= 4'b1011;
    req(4'h4, 4'h2, 16'h001d);
    ok <= 4'b0111;
    req(4'h4, 4'h2, 16'h001e);
    ok <= 4'hf;
    req(4'h4, 4'h4, 16'h0);
    req(4'h8, 4'h8, 16'h0);
    i_mst.pulse(2);
    repeat (2) @(posedge pclk);
    stat(4'h4, 16'h001b);
    req(4'h8, 4'h8, 16'h0);
    ok <= 4'b1011;
    repeat (3) @(posedge pclk);
    stat(4'h4, 16'h001d);
    ok <= 4'hf;
    req(4'h8, 4'h8, 16'h0);
    ok <= 4'b0111;
    repeat (3) @(posedge pclk);
    stat(4'h2, 16'h001e);
    ok <= 4'hf;
    $display("done states");
  endtask

  task t_pd_event;
    int n;
    din <= 16'h81c3;
    flt <= 4'b0101;
    repeat (8) @(posedge pclk);
    i_mst.pulse(0);
    wait_pd(n);
    `CHK("pd event", 1, n)
    `CHK("proc_in", 16'h81c3, proc_in)
    `CHK("io_status", 32'h30, io_status)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("proc word", 32'h81c3, rd)
    flt <= 4'h0;
    repeat (12) @(posedge pclk);
    i_mst.rx_q.delete();
    $display("done event mode");
  endtask

  task t_pd_sync;
    int n;
    logic early;
    early = 1'b0;
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h14, 32'h6);
    din <= 16'h1234;
    i_mst.pulse(1);
    repeat (6) @(negedge pclk) early = early | pd_update;
    @(posedge pclk);
    din <= 16'hfedc;
    wait_pd(n);
    `CHK("pd early", 1'b0, early)
    `CHK("pd late", 3, n)
    `CHK("sampled", 16'h1234, proc_in)
    $display("done sync mode");
  endtask

  task t_emcy;
    logic [15:0] ec[4] = '{16'h3001, 16'h3002, 16'h3003, 16'h4001};
    logic [7:0] dg[4] = '{8'h01, 8'h02, 8'h03, 8'h06};
    for (int k = 0; k < 4; k++) begin
      flt <= 4'h1 << k;
      repeat (8) @(posedge pclk);
      m = i_mst.rx_q.size() > 0 ? i_mst.rx_q[0] : 64'h0;
      `CHK("code", ec[k], m[15:0])
      `CHK("ereg", k < 3 ? 8'h04 : 8'h10, m[23:16])
      `CHK("diag", {dg[k], 8'h0}, m[39:24])
      i_mst.rx_q.delete();
      flt <= 4'h0;
      repeat (8) @(posedge pclk);
      m = i_mst.rx_q.size() > 0 ? i_mst.rx_q[0] : 64'h0;
      `CHK("clear", {dg[k], 32'h0}, m[39:0])
      i_mst.rx_q.delete();
    end
    flt <= 4'b1001;
    repeat (8) @(posedge pclk);
    m = i_mst.rx_q.size() > 0 ? i_mst.rx_q[0] : 64'h0;
    `CHK("count", 2, i_mst.rx_q.size())
    `CHK("first", 16'h3001, m[15:0])
    flt <= 4'h0;
    $display("done emergency");
  endtask

  task t_regs;
    apb(1'b0, 8'h3c, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, 8'h28, 32'h1);
    @(negedge pclk);
    `CHK("restore", 1'b1, restore_defaults)
    $display("done registers");
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // The watchdog allows about fifteen times the expected run length.
  initial begin
    #(5000 * 100);
    fail_count++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    din = 16'h0;
    flt = 4'h0;
    ok = 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_states();
    t_pd_event();
    t_emcy();
    t_pd_sync();
    t_regs();
    conclude();
  end
endmodule

// ===== logic/fsd_consts.vh
`ifndef FSD_CONSTS_VH
`define FSD_CONSTS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define FSD_CLK_PERIOD_NS 100
`define FSD_IN_DELAY_NS 1000
`define FSD_OUT_DELAY_NS 2000
`define FSD_IN_DELAY_CYC ((`FSD_IN_DELAY_NS + `FSD_CLK_PERIOD_NS - 1) / `FSD_CLK_PERIOD_NS)
`define FSD_OUT_DELAY_CYC ((`FSD_OUT_DELAY_NS + `FSD_CLK_PERIOD_NS - 1) / `FSD_CLK_PERIOD_NS)
`define FSD_SAMPLE_CYC 10

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FSD_OFF_CTRL 8'h00
`define FSD_OFF_STATUS 8'h04
`define FSD_OFF_CODE 8'h08
`define FSD_OFF_CONFIG 8'h0c
`define FSD_OFF_IN_DLY 8'h10
`define FSD_OFF_OUT_DLY 8'h14
`define FSD_OFF_PROC_IN 8'h18
`define FSD_OFF_IO_STAT 8'h1c
`define FSD_OFF_EMCY_LO 8'h20
`define FSD_OFF_EMCY_HI 8'h24
`define FSD_OFF_RESTORE 8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FSD_ACK_BIT 4
`define FSD_ERR_BIT 4
`define FSD_IOS_UNDERVOLT_BIT 5
`define FSD_IOS_OVERLOAD_BIT 4
`define FSD_EREG_SUPPLY_BIT 2
`define FSD_EREG_TEMP_BIT 4

// ----------------------------------------------------------------
// State encodings and status codes
// ----------------------------------------------------------------
`define FSD_ST_INIT 4'h1
`define FSD_ST_PREOP 4'h2
`define FSD_ST_BOOT 4'h3
`define FSD_ST_SAFEOP 4'h4
`define FSD_ST_OP 4'h8
`define FSD_CODE_OK 16'h0000
`define FSD_CODE_BAD_CHANGE 16'h0011
`define FSD_CODE_UNKNOWN 16'h0012
`define FSD_CODE_MBX_BOOT 16'h0015
`define FSD_CODE_MBX_PREOP 16'h0016
`define FSD_CODE_SM_CFG 16'h0017
`define FSD_CODE_WDOG 16'h001b
`define FSD_CODE_OUT_CFG 16'h001d
`define FSD_CODE_IN_CFG 16'h001e

// ----------------------------------------------------------------
// Emergency message codes, diagnostic codes and the restore value
// ----------------------------------------------------------------
`define FSD_EM_RESET 16'h0000
`define FSD_EM_OVERCUR 16'h3001
`define FSD_EM_SURGE 16'h3002
`define FSD_EM_UNDERVOLT 16'h3003
`define FSD_EM_OVERTEMP 16'h4001
`define FSD_DIAG_OVERCUR 8'h01
`define FSD_DIAG_SURGE 8'h02
`define FSD_DIAG_UNDERVOLT 8'h03
`define FSD_DIAG_OVERTEMP 8'h06
`define FSD_RESTORE_MAGIC 32'h00000001

`endif

// ===== logic/fsd_delay.v
`timescale 1ns/1ps
`include "fsd_consts.vh"

// One-shot delay: a start pulse gives a done pulse after delay_cyc + 1 edges.
module fsd_delay #(
  parameter W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [W-1:0] delay_cyc,
  output reg done
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  reg [W-1:0] cnt_q;
  reg busy_q;

  // A new start restarts the count, so a late sync edge is never merged.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= delay_cyc;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == {W{1'b0}}) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ===== logic/fsd_slave_app.v
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fsd_consts.vh"

module fsd_slave_app #(
  parameter DLY_W = 16,
  parameter SAMPLE_CYC = `FSD_SAMPLE_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] device_input_number,
  input wire sup_overcurrent,
  input wire sup_surge,
  input wire sup_undervoltage,
  input wire overtemp,
  input wire mbx_cfg_ok,
  input wire sm_cfg_ok,
  input wire out_cfg_ok,
  input wire in_cfg_ok,
  input wire sm_watchdog,
  input wire sm_event,
  input wire sync0,
  output reg [15:0] proc_in,
  output reg [31:0] io_status,
  output reg pd_update,
  output reg emcy_valid,
  output reg [63:0] emcy_data,
  output reg restore_defaults
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr_take = psel & penable & pready & pwrite;
  wire wr_ctrl = wr_take & (paddr == `FSD_OFF_CTRL);

  reg [3:0] state_q;
  reg err_q;
  reg [15:0] code_q;
  reg [3:0] req_q;
  reg req_pend_q;
  reg ack_q;
  reg mode_dc_q;
  reg [DLY_W-1:0] in_dly_q;
  reg [DLY_W-1:0] out_dly_q;
  reg [15:0] samp_q;
  reg [31:0] ios_samp_q;
  reg [3:0] src_q;
  reg [3:0] pend_q;
  reg out_bad_q;
  reg in_bad_q;
  reg [15:0] free_cnt_q;
  reg [31:0] rd_d;
  reg hit_d;

  // Reset delays are sized here, so the header's plain counts never meet the register width.
  localparam integer IN_DLY_RST = `FSD_IN_DELAY_CYC;
  localparam integer OUT_DLY_RST = `FSD_OUT_DELAY_CYC;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Reserved bits read zero; an unmapped address answers with an error.
  always @* begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (paddr)
      `FSD_OFF_CTRL: rd_d = {27'h0000000, 1'b0, req_q};
      `FSD_OFF_STATUS: rd_d = {27'h0000000, err_q, state_q};
      `FSD_OFF_CODE: rd_d = {16'h0000, code_q};
      `FSD_OFF_CONFIG: rd_d = {31'h00000000, mode_dc_q};
      `FSD_OFF_IN_DLY: rd_d = {{(32-DLY_W){1'b0}}, in_dly_q};
      `FSD_OFF_OUT_DLY: rd_d = {{(32-DLY_W){1'b0}}, out_dly_q};
      `FSD_OFF_PROC_IN: rd_d = {16'h0000, proc_in};
      `FSD_OFF_IO_STAT: rd_d = io_status;
      `FSD_OFF_EMCY_LO: rd_d = emcy_data[31:0];
      `FSD_OFF_EMCY_HI: rd_d = emcy_data[63:32];
      `FSD_OFF_RESTORE: rd_d = {31'h00000000, restore_defaults};
      default: hit_d = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle, so the access phase ends at once.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_d;
      prdata <= (setup & ~pwrite & hit_d) ? rd_d : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Writable configuration
  // ----------------------------------------------------------------
  // The restore flag is sticky until the next power-on reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_dc_q <= 1'b0;
      in_dly_q <= IN_DLY_RST[DLY_W-1:0];
      out_dly_q <= OUT_DLY_RST[DLY_W-1:0];
      restore_defaults <= 1'b0;
      req_q <= `FSD_ST_INIT;
      req_pend_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      req_pend_q <= wr_ctrl;
      ack_q <= wr_ctrl & pwdata[`FSD_ACK_BIT];
      if (wr_ctrl) begin
        req_q <= pwdata[3:0];
      end
      if (wr_take && paddr == `FSD_OFF_CONFIG) begin
        mode_dc_q <= pwdata[0];
      end
      if (wr_take && paddr == `FSD_OFF_IN_DLY) begin
        in_dly_q <= pwdata[DLY_W-1:0];
      end
      if (wr_take && paddr == `FSD_OFF_OUT_DLY) begin
        out_dly_q <= pwdata[DLY_W-1:0];
      end
      if (wr_take && paddr == `FSD_OFF_RESTORE && pwdata == `FSD_RESTORE_MAGIC) begin
        restore_defaults <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  localparam [3:0] ST_I = `FSD_ST_INIT;
  localparam [3:0] ST_P = `FSD_ST_PREOP;
  localparam [3:0] ST_B = `FSD_ST_BOOT;
  localparam [3:0] ST_S = `FSD_ST_SAFEOP;
  localparam [3:0] ST_O = `FSD_ST_OP;

  reg known_d;
  reg illegal_d;
  reg [3:0] state_d;
  reg err_d;
  reg [15:0] code_d;
  wire run_state = (state_q == ST_O) | (state_q == ST_S);
  wire out_rise = ~out_cfg_ok & ~out_bad_q;
  wire in_rise = ~in_cfg_ok & ~in_bad_q;
  wire p_to_s = (state_q == ST_P) & (req_q == ST_S);

  // Faults detected while running are checked last, so they win over a request.
  always @* begin
    state_d = state_q;
    err_d = err_q;
    code_d = code_q;
    case (req_q)
      ST_I, ST_P, ST_B, ST_S, ST_O: known_d = 1'b1;
      default: known_d = 1'b0;
    endcase
    illegal_d = ((state_q == ST_I) & ((req_q == ST_S) | (req_q == ST_O))) |
                ((state_q == ST_P) & (req_q == ST_O)) |
                ((req_q == ST_B) & (state_q != ST_I) & (state_q != ST_B)) |
                ((state_q == ST_B) & (req_q != ST_I) & (req_q != ST_B));
    if (ack_q) begin
      err_d = 1'b0;
    end
    if (req_pend_q) begin
      if (!known_d) begin
        err_d = 1'b1;
        code_d = `FSD_CODE_UNKNOWN;
      end else if (illegal_d) begin
        err_d = 1'b1;
        code_d = `FSD_CODE_BAD_CHANGE;
      end else if (state_q == ST_I && req_q == ST_B && !mbx_cfg_ok) begin
        err_d = 1'b1;
        code_d = `FSD_CODE_MBX_BOOT;
      end else if (state_q == ST_I && req_q == ST_P && !mbx_cfg_ok) begin
        err_d = 1'b1;
        code_d = `FSD_CODE_MBX_PREOP;
      end else if ((p_to_s || (state_q == ST_S && req_q == ST_O)) && !sm_cfg_ok) begin
        err_d = 1'b1;
        code_d = `FSD_CODE_SM_CFG;
      end else if (p_to_s && !out_cfg_ok) begin
        err_d = 1'b1;
        code_d = `FSD_CODE_OUT_CFG;
      end else if (p_to_s && !in_cfg_ok) begin
        state_d = ST_P;
        err_d = 1'b1;
        code_d = `FSD_CODE_IN_CFG;
      end else begin
        state_d = req_q;
        err_d = 1'b0;
        code_d = `FSD_CODE_OK;
      end
    end
    if (run_state) begin
      if (sm_watchdog) begin
        state_d = ST_S;
        err_d = 1'b1;
        code_d = `FSD_CODE_WDOG;
      end else if (in_rise) begin
        state_d = ST_P;
        err_d = 1'b1;
        code_d = `FSD_CODE_IN_CFG;
      end else if (out_rise) begin
        state_d = ST_S;
        err_d = 1'b1;
        code_d = `FSD_CODE_OUT_CFG;
      end
    end
  end

  // Failed requests only touch flag and code, never the state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_I;
      err_q <= 1'b0;
      code_q <= `FSD_CODE_OK;
      out_bad_q <= 1'b0;
      in_bad_q <= 1'b0;
    end else begin
      state_q <= state_d;
      err_q <= err_d;
      code_q <= code_d;
      out_bad_q <= ~out_cfg_ok;
      in_bad_q <= ~in_cfg_ok;
    end
  end

  // ----------------------------------------------------------------
  // Input sampling and process data
  // ----------------------------------------------------------------
  wire in_dly_done;
  wire out_dly_done;
  wire free_tick = (free_cnt_q == 16'h0000);
  wire sample_now = mode_dc_q ? in_dly_done : free_tick;
  wire publish_now = mode_dc_q ? out_dly_done : sm_event;

  fsd_delay #(.W(DLY_W)) u_in_dly (
    .pclk(pclk),
    .presetn(presetn),
    .start(sync0 & mode_dc_q),
    .delay_cyc(in_dly_q),
    .done(in_dly_done)
  );

  fsd_delay #(.W(DLY_W)) u_out_dly (
    .pclk(pclk),
    .presetn(presetn),
    .start(sync0 & mode_dc_q),
    .delay_cyc(out_dly_q),
    .done(out_dly_done)
  );

  // Free-running sampler keeps going in both modes, but is only used in the default one.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_cnt_q <= 16'h0000;
      samp_q <= 16'h0000;
      ios_samp_q <= 32'h00000000;
      proc_in <= 16'h0000;
      io_status <= 32'h00000000;
      pd_update <= 1'b0;
    end else begin
      free_cnt_q <= free_tick ? SAMPLE_CYC[15:0] - 16'h0001 : free_cnt_q - 16'h0001;
      if (sample_now) begin
        samp_q <= device_input_number;
        ios_samp_q <= 32'h00000000;
        ios_samp_q[`FSD_IOS_UNDERVOLT_BIT] <= sup_undervoltage;
        ios_samp_q[`FSD_IOS_OVERLOAD_BIT] <= sup_overcurrent;
      end
      pd_update <= publish_now;
      if (publish_now) begin
        proc_in <= samp_q;
        io_status <= ios_samp_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Emergency messages
  // ----------------------------------------------------------------
  wire [3:0] src = {overtemp, sup_undervoltage, sup_surge, sup_overcurrent};
  wire [3:0] change = src ^ src_q;
  reg [3:0] sel_d;
  reg [15:0] em_code_d;
  reg [7:0] em_diag_d;
  reg [7:0] em_ereg_d;

  // Lowest source index goes first; the rest wait in their pending bits.
  always @* begin
    sel_d = 4'h0;
    em_code_d = `FSD_EM_RESET;
    em_diag_d = 8'h00;
    em_ereg_d = 8'h00;
    em_ereg_d[`FSD_EREG_SUPPLY_BIT] = |src_q[2:0];
    em_ereg_d[`FSD_EREG_TEMP_BIT] = src_q[3];
    if (pend_q[0]) begin
      sel_d = 4'h1;
      em_code_d = src_q[0] ? `FSD_EM_OVERCUR : `FSD_EM_RESET;
      em_diag_d = `FSD_DIAG_OVERCUR;
    end else if (pend_q[1]) begin
      sel_d = 4'h2;
      em_code_d = src_q[1] ? `FSD_EM_SURGE : `FSD_EM_RESET;
      em_diag_d = `FSD_DIAG_SURGE;
    end else if (pend_q[2]) begin
      sel_d = 4'h4;
      em_code_d = src_q[2] ? `FSD_EM_UNDERVOLT : `FSD_EM_RESET;
      em_diag_d = `FSD_DIAG_UNDERVOLT;
    end else if (pend_q[3]) begin
      sel_d = 4'h8;
      em_code_d = src_q[3] ? `FSD_EM_OVERTEMP : `FSD_EM_RESET;
      em_diag_d = `FSD_DIAG_OVERTEMP;
    end
  end

  // A message is a single pulse; no answer is awaited from the master.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 4'h0;
      pend_q <= 4'h0;
      emcy_valid <= 1'b0;
      emcy_data <= 64'h0000000000000000;
    end else begin
      src_q <= src;
      pend_q <= (pend_q & ~sel_d) | change; // Set wins over the send-clear.
      emcy_valid <= |sel_d;
      if (|sel_d) begin
        emcy_data <= {24'h000000, em_diag_d, 8'h00, em_ereg_d, em_code_d};
      end
    end
  end

endmodule
